// *** logic/ieb_consts.svh ***
// Summary of operation
// - Bank three bit 14 gates calendar clock request.
// - Bank three bit 13 gates DMA five done.
// - Bank three bit 12 gates converter event.
// - Bank three bit 11 gates converter error.
// - Unimplemented bits ignore writes, read zero.
// - Bank four bits 15/14 gate audio left/right.
// - Bank four bit 6 gates first CAN.
// - Bank four bit 5 gates DMA seven done.
// - Bank four bit 4 gates DMA six done.
// - Bank four bit 3 gates checksum generator.
// - Bank four bits 2/1 gate UART errors.
// - Without CAN, CAN requests stay blocked.
// - Without audio DAC, audio requests stay blocked.
`ifndef IEB_CONSTS_SVH
`define IEB_CONSTS_SVH
// Register word addresses on the plain register port.
`define IEB_ADDR_BANK_THREE 4'h0
`define IEB_ADDR_BANK_FOUR 4'h1
// Writable bit masks of each bank.
`define IEB_MASK_BANK_THREE 16'h7800
`define IEB_MASK_BANK_FOUR 16'hc07e
// Reset value of both banks.
`define IEB_RESET_VALUE 16'h0000
// Field positions.
`define IEB_BIT_CALENDAR 14
`define IEB_BIT_DMA5 13
`define IEB_BIT_CONV_EVENT 12
`define IEB_BIT_CONV_ERROR 11
`define IEB_BIT_AUDIO_LEFT 15
`define IEB_BIT_AUDIO_RIGHT 14
`define IEB_BIT_CAN_TX 6
`define IEB_BIT_DMA7 5
`define IEB_BIT_DMA6 4
`define IEB_BIT_CHECKSUM 3
`define IEB_BIT_UART2_ERR 2
`define IEB_BIT_UART1_ERR 1
`endif

// *** logic/ieb_gate.sv ***
`timescale 1ns/1ns
`default_nettype none
// Combines pending flags with enables for one bank of sources.
module ieb_gate #(
  parameter int WIDTH = 16
) (
  input wire logic [WIDTH-1:0] pend_i,
  input wire logic [WIDTH-1:0] en_i,
  output logic [WIDTH-1:0] req_o
);
  // A width of zero cannot carry any source.
  if (WIDTH < 1) begin : g_chk
    $error("ieb_gate needs WIDTH of at least one.");
  end
  // Each source is forwarded only while both of its inputs are high.
  for (genvar i = 0; i < WIDTH; i++) begin : g_bit
    assign req_o[i] = pend_i[i] & en_i[i];
  end
endmodule : ieb_gate
`default_nettype wire

// *** logic/ieb_pkg.sv ***
`default_nettype none
package ieb_pkg;
  // One register word of the enable bank.
  typedef logic [15:0] ieb_word_t;
  // Register selector decoded from the address.
  typedef enum logic [1:0] {IEB_SEL_NONE, IEB_SEL_THREE, IEB_SEL_FOUR} ieb_sel_t;
endpackage : ieb_pkg
`default_nettype wire

// *** logic/ieb_top.sv ***
// Chosen here: the plain strobed port and the address map.
`timescale 1ns/1ns
`default_nettype none
`include "ieb_consts.svh"
// Interrupt enable banks three and four with request gating.
module ieb_top #(
  parameter bit HAS_CAN = 1'b1,
  parameter bit HAS_AUDIO_DAC = 1'b1
) (
  input wire logic ref_clk_i,
  input wire logic sys_rst_i,
  input wire logic [3:0] reg_addr_i,
  input wire ieb_pkg::ieb_word_t reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output ieb_pkg::ieb_word_t reg_rdata_o,
  input wire ieb_pkg::ieb_word_t pend_three_i,
  input wire ieb_pkg::ieb_word_t pend_four_i,
  output ieb_pkg::ieb_word_t req_three_o,
  output ieb_pkg::ieb_word_t req_four_o
);
  import ieb_pkg::*;

  // Stored enable banks.
  ieb_word_t bank_three_q;
  ieb_word_t bank_four_q;
  // Read data register.
  ieb_word_t rdata_q;
  // Decoded register selection.
  ieb_sel_t sel;
  // Mask of bank four bits that this variant really has.
  ieb_word_t four_mask;
  // Bank four enables after variant masking.
  ieb_word_t four_eff;

  // Address decode; unmapped addresses select nothing.
  always_comb begin
    unique case (reg_addr_i)
      `IEB_ADDR_BANK_THREE: sel = IEB_SEL_THREE;
      `IEB_ADDR_BANK_FOUR: sel = IEB_SEL_FOUR;
      default: sel = IEB_SEL_NONE;
    endcase
  end

  // Variants without CAN or audio DAC lose those enables entirely.
  always_comb begin
    four_mask = `IEB_MASK_BANK_FOUR;
    if (!HAS_CAN) begin
      four_mask[`IEB_BIT_CAN_TX] = 1'b0;
    end
    if (!HAS_AUDIO_DAC) begin
      four_mask[`IEB_BIT_AUDIO_LEFT] = 1'b0;
      four_mask[`IEB_BIT_AUDIO_RIGHT] = 1'b0;
    end
  end

  // Bank three holds calendar, DMA five and converter enables; other bits are dropped.
  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      bank_three_q <= `IEB_RESET_VALUE;
    end else if (reg_wr_i && sel == IEB_SEL_THREE) begin
      bank_three_q <= reg_wdata_i & `IEB_MASK_BANK_THREE;
    end
  end

  // Bank four holds audio, CAN, DMA six/seven, checksum and UART enables.
  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      bank_four_q <= `IEB_RESET_VALUE;
    end else if (reg_wr_i && sel == IEB_SEL_FOUR) begin
      bank_four_q <= reg_wdata_i & four_mask;
    end
  end

  // Read data stand for exactly the cycle after the strobe; zero otherwise.
  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      rdata_q <= '0;
    end else if (reg_rd_i) begin
      unique case (sel)
        IEB_SEL_THREE: rdata_q <= bank_three_q;
        IEB_SEL_FOUR: rdata_q <= bank_four_q;
        IEB_SEL_NONE: rdata_q <= '0;
      endcase
    end else begin
      rdata_q <= '0;
    end
  end

  assign reg_rdata_o = rdata_q;
  // Masking again keeps gating correct even if the variant straps differ from stored state.
  assign four_eff = bank_four_q & four_mask;

  // Gating of bank three sources.
  ieb_gate #(.WIDTH(16)) u_gate_three (
    .pend_i(pend_three_i),
    .en_i(bank_three_q),
    .req_o(req_three_o)
  );

  // Gating of bank four sources.
  ieb_gate #(.WIDTH(16)) u_gate_four (
    .pend_i(pend_four_i),
    .en_i(four_eff),
    .req_o(req_four_o)
  );

  // Every check below runs on the one clock and rests while reset is held.
  default clocking cb_main @(posedge ref_clk_i);
  endclocking
  default disable iff (sys_rst_i);

  // A write strobe aimed at bank three.
  sequence s_wr_three;
    reg_wr_i && sel == IEB_SEL_THREE;
  endsequence

  // A write strobe aimed at bank four.
  sequence s_wr_four;
    reg_wr_i && sel == IEB_SEL_FOUR;
  endsequence

  // A write strobe aimed at an address with no register behind it.
  sequence s_wr_none;
    reg_wr_i && sel == IEB_SEL_NONE;
  endsequence

  // A read strobe aimed at bank three.
  sequence s_rd_three;
    reg_rd_i && sel == IEB_SEL_THREE;
  endsequence

  // A read strobe aimed at bank four.
  sequence s_rd_four;
    reg_rd_i && sel == IEB_SEL_FOUR;
  endsequence

  // A read strobe aimed at an unmapped address.
  sequence s_rd_none;
    reg_rd_i && sel == IEB_SEL_NONE;
  endsequence

  // Software writes bank three and reads it back on the very next cycle.
  sequence s_wr_rd_three;
    s_wr_three ##1 s_rd_three;
  endsequence

  // Software writes bank four and reads it back on the very next cycle.
  sequence s_wr_rd_four;
    s_wr_four ##1 s_rd_four;
  endsequence

  // One bank three field takes the written bit on the edge after the strobe.
  property p_three_field(int pos);
    s_wr_three |=> bank_three_q[pos] == $past(reg_wdata_i[pos]);
  endproperty

  // One bank four field takes the written bit, but only where the variant has the source.
  property p_four_field(int pos, bit present);
    s_wr_four |=> bank_four_q[pos] == ($past(reg_wdata_i[pos]) && present);
  endproperty

  // One bank three request passes exactly while pending and enabled.
  property p_three_gate(int pos);
    req_three_o[pos] == (pend_three_i[pos] && bank_three_q[pos]);
  endproperty

  // One bank four request passes exactly while pending, enabled and present.
  property p_four_gate(int pos, bit present);
    req_four_o[pos] == (pend_four_i[pos] && bank_four_q[pos] && present);
  endproperty

  // Bank three fields: each enable follows its own write and nothing else.
  AST_CAL_WRITE: assert property (p_three_field(`IEB_BIT_CALENDAR))
    else $error("Calendar clock enable did not follow a write.");
  AST_DMA5_WRITE: assert property (p_three_field(`IEB_BIT_DMA5))
    else $error("DMA five enable did not follow a write.");
  AST_CONV_EVENT_WRITE: assert property (p_three_field(`IEB_BIT_CONV_EVENT))
    else $error("Converter event enable did not follow a write.");
  AST_CONV_ERROR_WRITE: assert property (p_three_field(`IEB_BIT_CONV_ERROR))
    else $error("Converter error enable did not follow a write.");

  // Bank three gates, one per source.
  // A stuck gate would pass a request that software believes is masked.
  AST_CAL_GATE: assert property (p_three_gate(`IEB_BIT_CALENDAR))
    else $error("Calendar clock request gated wrongly.");
  AST_DMA5_GATE: assert property (p_three_gate(`IEB_BIT_DMA5))
    else $error("DMA five request gated wrongly.");
  AST_CONV_EVENT_GATE: assert property (p_three_gate(`IEB_BIT_CONV_EVENT))
    else $error("Converter event request gated wrongly.");
  AST_CONV_ERROR_GATE: assert property (p_three_gate(`IEB_BIT_CONV_ERROR))
    else $error("Converter error request gated wrongly.");

  // Bank four fields; the optional sources must stay clear on variants without them.
  // The variant straps are parameters, so these hold for every build of the block.
  AST_AUDIO_LEFT_WRITE: assert property (p_four_field(`IEB_BIT_AUDIO_LEFT, HAS_AUDIO_DAC))
    else $error("Audio left enable did not follow a write.");
  AST_AUDIO_RIGHT_WRITE: assert property (p_four_field(`IEB_BIT_AUDIO_RIGHT, HAS_AUDIO_DAC))
    else $error("Audio right enable did not follow a write.");
  AST_CAN_WRITE: assert property (p_four_field(`IEB_BIT_CAN_TX, HAS_CAN))
    else $error("CAN enable did not follow a write.");
  AST_DMA7_WRITE: assert property (p_four_field(`IEB_BIT_DMA7, 1'b1))
    else $error("DMA seven enable did not follow a write.");
  AST_DMA6_WRITE: assert property (p_four_field(`IEB_BIT_DMA6, 1'b1))
    else $error("DMA six enable did not follow a write.");
  AST_CHECKSUM_WRITE: assert property (p_four_field(`IEB_BIT_CHECKSUM, 1'b1))
    else $error("Checksum enable did not follow a write.");
  AST_UART2_WRITE: assert property (p_four_field(`IEB_BIT_UART2_ERR, 1'b1))
    else $error("Second UART error enable did not follow a write.");
  AST_UART1_WRITE: assert property (p_four_field(`IEB_BIT_UART1_ERR, 1'b1))
    else $error("First UART error enable did not follow a write.");

  // Bank four gates, one per source.
  // An absent source must never reach arbitration, whatever its pending pin shows.
  AST_AUDIO_LEFT_GATE: assert property (p_four_gate(`IEB_BIT_AUDIO_LEFT, HAS_AUDIO_DAC))
    else $error("Audio left request gated wrongly.");
  AST_AUDIO_RIGHT_GATE: assert property (p_four_gate(`IEB_BIT_AUDIO_RIGHT, HAS_AUDIO_DAC))
    else $error("Audio right request gated wrongly.");
  AST_CAN_GATE: assert property (p_four_gate(`IEB_BIT_CAN_TX, HAS_CAN))
    else $error("CAN request gated wrongly.");
  AST_DMA7_GATE: assert property (p_four_gate(`IEB_BIT_DMA7, 1'b1))
    else $error("DMA seven request gated wrongly.");
  AST_DMA6_GATE: assert property (p_four_gate(`IEB_BIT_DMA6, 1'b1))
    else $error("DMA six request gated wrongly.");
  AST_CHECKSUM_GATE: assert property (p_four_gate(`IEB_BIT_CHECKSUM, 1'b1))
    else $error("Checksum request gated wrongly.");
  AST_UART2_GATE: assert property (p_four_gate(`IEB_BIT_UART2_ERR, 1'b1))
    else $error("Second UART error request gated wrongly.");
  AST_UART1_GATE: assert property (p_four_gate(`IEB_BIT_UART1_ERR, 1'b1))
    else $error("First UART error request gated wrongly.");

  // Whole words: no request passes without its enable, reserved ones included.
  AST_REQ_GATED: assert property ((req_three_o == (pend_three_i & bank_three_q)) && (req_four_o == (pend_four_i & four_eff)))
    else $error("Request forwarded without matching enable.");

  // Unimplemented bank three bits are never stored.
  AST_THREE_RSVD: assert property ((bank_three_q & ~`IEB_MASK_BANK_THREE) == 16'h0000)
    else $error("Bank three reserved bit set.");

  // Unimplemented bank four bits are never stored.
  AST_FOUR_RSVD: assert property ((bank_four_q & ~`IEB_MASK_BANK_FOUR) == 16'h0000)
    else $error("Bank four reserved bit set.");

  // Unimplemented bank three bits read as zero.
  AST_THREE_RSVD_READ: assert property (s_rd_three |=> (reg_rdata_o & ~`IEB_MASK_BANK_THREE) == 16'h0000)
    else $error("Bank three reserved bit read as one.");

  // Unimplemented bank four bits read as zero.
  AST_FOUR_RSVD_READ: assert property (s_rd_four |=> (reg_rdata_o & ~`IEB_MASK_BANK_FOUR) == 16'h0000)
    else $error("Bank four reserved bit read as one.");

  // A write to an unmapped address changes neither bank.
  // Software probing the address space must not disturb live enables.
  AST_UNMAPPED_WRITE: assert property (s_wr_none |=> $stable(bank_three_q) && $stable(bank_four_q))
    else $error("Unmapped write changed an enable bank.");

  // A write to bank three leaves bank four alone.
  AST_THREE_KEEPS_FOUR: assert property (s_wr_three |=> $stable(bank_four_q))
    else $error("Bank three write disturbed bank four.");

  // A write to bank four leaves bank three alone.
  AST_FOUR_KEEPS_THREE: assert property (s_wr_four |=> $stable(bank_three_q))
    else $error("Bank four write disturbed bank three.");

  // A read has no side effect on either bank.
  AST_READ_NO_SIDE_EFFECT: assert property (reg_rd_i && !reg_wr_i |=> $stable(bank_three_q) && $stable(bank_four_q))
    else $error("Read changed an enable bank.");

  // A read of bank three returns the bank as it stood at the strobe.
  AST_READ_THREE: assert property (s_rd_three |=> reg_rdata_o == $past(bank_three_q))
    else $error("Bank three read returned wrong data.");

  // A read of bank four returns the bank as it stood at the strobe.
  AST_READ_FOUR: assert property (s_rd_four |=> reg_rdata_o == $past(bank_four_q))
    else $error("Bank four read returned wrong data.");

  // A read of an unmapped address returns zero.
  AST_READ_NONE: assert property (s_rd_none |=> reg_rdata_o == 16'h0000)
    else $error("Unmapped read returned nonzero data.");

  // Read data vanish in any cycle that does not follow a read strobe.
  // Holding them would let a later sampler mistake stale data for a fresh answer.
  AST_RD_ONE_CYCLE: assert property (!$past(reg_rd_i) |-> reg_rdata_o == 16'h0000)
    else $error("Read data stood without a read strobe.");

  // A write followed at once by a read returns the masked written word.
  AST_WR_RD_THREE: assert property (s_wr_rd_three |=> reg_rdata_o == ($past(reg_wdata_i, 2) & `IEB_MASK_BANK_THREE))
    else $error("Bank three back-to-back read missed the write.");

  // The same for bank four, with the variant mask applied.
  AST_WR_RD_FOUR: assert property (s_wr_rd_four |=> reg_rdata_o == ($past(reg_wdata_i, 2) & four_mask))
    else $error("Bank four back-to-back read missed the write.");

  // Right after reset is released, both banks are at their reset value.
  AST_RESET_VALUE: assert property ($fell(sys_rst_i) |-> bank_three_q == `IEB_RESET_VALUE && bank_four_q == `IEB_RESET_VALUE)
    else $error("Enable bank not at its reset value.");

  // Without CAN the CAN request never passes.
  AST_NO_CAN: assert property (!HAS_CAN |-> !req_four_o[`IEB_BIT_CAN_TX])
    else $error("CAN request passed on variant without CAN.");

  // Without CAN the CAN enable is never stored, so it also reads zero.
  AST_NO_CAN_STORED: assert property (!HAS_CAN |-> !bank_four_q[`IEB_BIT_CAN_TX])
    else $error("CAN enable stored on variant without CAN.");

  // Without audio DAC its requests never pass.
  AST_NO_DAC: assert property (!HAS_AUDIO_DAC |-> req_four_o[15:14] == 2'b00)
    else $error("Audio request passed on variant without DAC.");

  // Without audio DAC its enables are never stored, so they also read zero.
  AST_NO_DAC_STORED: assert property (!HAS_AUDIO_DAC |-> bank_four_q[15:14] == 2'b00)
    else $error("Audio enable stored on variant without DAC.");
endmodule : ieb_top
`default_nettype wire

// *** tb/tb_ieb_top.sv ***
`timescale 1ns/1ns
`default_nettype none
`include "ieb_consts.svh"
// Drives both enable banks over the register port and checks reads and gated requests.
module tb_ieb_top;
  import ieb_pkg::*;
  logic ref_clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic [3:0] reg_addr_i = 4'h0;
  ieb_word_t reg_wdata_i = 16'h0000;
  logic reg_wr_i = 1'b0;
  logic reg_rd_i = 1'b0;
  ieb_word_t pend_three_i = 16'h0000;
  ieb_word_t pend_four_i = 16'h0000;
  ieb_word_t reg_rdata_o, req_three_o, req_four_o, bare_rdata, bare_req3, bare_req4;
  // Shadow banks kept by the driver, and copies delayed one edge to match the design.
  ieb_word_t sh3 = 16'h0000, sh4 = 16'h0000, d3 = 16'h0000, d4 = 16'h0000;
  ieb_word_t exp_q[$], bare_q[$];
  logic rd_q = 1'b0;
  int seed = 54;
  int bad_count = 0;
  int cmp_count = 0;
  // Full variant, and a variant without CAN and audio DAC sharing the same inputs.
  ieb_top u_dut (.ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
    .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .pend_three_i(pend_three_i),
    .pend_four_i(pend_four_i), .req_three_o(req_three_o), .req_four_o(req_four_o));
  ieb_top #(.HAS_CAN(1'b0), .HAS_AUDIO_DAC(1'b0)) u_dut_bare (.ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i),
    .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_rdata_o(bare_rdata), .pend_three_i(pend_three_i), .pend_four_i(pend_four_i), .req_three_o(bare_req3),
    .req_four_o(bare_req4));
  // Clock at 250 MHz.
  always #2 ref_clk_i = ~ref_clk_i;
  // Counts every comparison and reports each mismatch at once.
  task automatic chk(input ieb_word_t got, input ieb_word_t exp);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // Prints the verdict and stops the run.
  task automatic end_of_test();
    if (bad_count == 0 && cmp_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : end_of_test
  // One bus cycle: op 0 idle, 1 write, 2 read; every signal is set once per edge so strobes can run back to back.
  task automatic bus(input int op, input logic [3:0] a, input ieb_word_t d);
    @(posedge ref_clk_i);
    reg_wr_i <= (op == 1);
    reg_rd_i <= (op == 2);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    pend_three_i <= 16'($random(seed));
    pend_four_i <= 16'($random(seed));
    if (op == 1 && a == `IEB_ADDR_BANK_THREE) sh3 <= d & 16'h7800;
    if (op == 1 && a == `IEB_ADDR_BANK_FOUR) sh4 <= d & 16'hc07e;
    if (op == 2) begin
      exp_q.push_back(a == 4'h0 ? sh3 : (a == 4'h1 ? sh4 : 16'h0000));
      bare_q.push_back(a == 4'h0 ? sh3 : (a == 4'h1 ? (sh4 & 16'h003e) : 16'h0000));
    end
  endtask : bus
  // Read data stand only in the cycle after the strobe, so they are taken off the queue exactly then.
  always @(posedge ref_clk_i) begin
    rd_q <= reg_rd_i;
    d3 <= sh3;
    d4 <= sh4;
    if (sys_rst_i) begin
      // Read data are unknown until the first edge inside reset clears them.
    end else if (rd_q) begin
      chk(reg_rdata_o, exp_q.pop_front());
      chk(bare_rdata, bare_q.pop_front());
    end else begin
      chk(reg_rdata_o, 16'h0000);
    end
  end
  // Requests are combinational, so they are sampled mid-cycle, well away from any edge.
  always @(negedge ref_clk_i) begin
    chk(req_three_o, pend_three_i & d3);
    chk(req_four_o, pend_four_i & d4);
    chk(bare_req3, pend_three_i & d3);
    chk(bare_req4, pend_four_i & d4 & 16'h003e);
  end
  // A hang past the expected few hundred cycles is a failure.
  initial begin
    repeat (3000) @(posedge ref_clk_i);
    bad_count++;
    end_of_test();
  end
  // Reset, reset values, a walking one through every position, unmapped accesses, then random traffic.
  initial begin
    repeat (16) @(posedge ref_clk_i);
    sys_rst_i <= 1'b0;
    bus(2, 4'h0, 16'h0000);
    bus(2, 4'h1, 16'h0000);
    for (int i = 0; i < 16; i++) begin
      bus(1, 4'h0, 16'h0001 << i);
      bus(2, 4'h0, 16'h0000);
      bus(1, 4'h1, 16'h0001 << i);
      bus(2, 4'h1, 16'h0000);
    end
    bus(1, 4'h0, 16'hffff);
    bus(1, 4'h1, 16'hffff);
    bus(1, 4'h3, 16'h0000);
    bus(2, 4'h3, 16'h0000);
    bus(2, 4'h0, 16'h0000);
    bus(2, 4'h1, 16'h0000);
    for (int i = 0; i < 300; i++) begin
      bus($unsigned($random(seed)) % 3, 4'($random(seed)) & 4'h3, 16'($random(seed)));
    end
    bus(0, 4'h0, 16'h0000);
    repeat (4) @(posedge ref_clk_i);
    end_of_test();
  end
endmodule : tb_ieb_top
`default_nettype wire
